// *** hdl/sac_pkg.sv ***
// Constants for the converter conversion control block
package sac_pkg;
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
  localparam logic [7:0] ADDR_INSEL    = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW  = 8'h0C;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
  localparam logic [7:0] ADDR_POWER    = 8'h14;
  // control_status_a fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START  = 6;
  localparam int BIT_AUTO   = 5;
  localparam int BIT_DONE   = 4;
  localparam int BIT_IE     = 3;
  // input_select_reg fields
  localparam int BIT_LEFT   = 5;
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES  = 25;
  localparam int NORMAL_SAMPLE_HALF = 3;
  localparam int FIRST_SAMPLE_HALF  = 27;
  localparam int AUTO_SAMPLE_HALF   = 4;
  localparam int SYNC_CPU_CYCLES    = 3;
  localparam logic [2:0] SRC_FREE = 3'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_WAIT = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_type;
endpackage : sac_pkg

// *** hdl/sac_top.sv ***
// Conversion sequencer, prescaler, result registers and AXI4-Lite slave
`timescale 1ns/1ps
module sac_top #(
  parameter int TRIG_WIDTH = 8
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [TRIG_WIDTH-1:0] trigger_in,
  input  wire logic [9:0]            sample_code,
  output logic                       sample_hold,
  output logic                       converter_clk,
  output logic [3:0]                 channel_select,
  output logic [1:0]                 reference_select,
  output logic                       converter_active,
  output logic                       conversion_done_flag
);
  if (TRIG_WIDTH < 1 || TRIG_WIDTH > 8) begin : g_bad_width
    $error("TRIG_WIDTH must be 1 to 8");
  end

  // Software state
  logic       power_gate, enable, start, auto_en, done, irq_en, left;
  logic [2:0] divsel, trig_sel;
  logic [3:0] mux_sw;
  logic [1:0] reference_select_sw;
  logic [9:0] res;
  logic       locked;
  // Bus handshake
  logic       aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // Sequencer
  sac_pkg::sac_state_type state;
  logic [6:0] pre_cnt;
  logic [5:0] half_cnt;
  logic       first_pending, single_run, auto_run;
  logic [2:0] sync_cnt;
  logic [1:0] trig_meta, trig_sync;
  logic       trig_prev;

  logic       next_power_gate, next_enable, next_start, next_auto_en, next_done, next_irq_en;
  logic       next_left, next_locked, next_aw_held, next_w_held;
  logic [2:0] next_divsel, next_trig_sel;
  logic [3:0] next_mux_sw, next_channel_select;
  logic [1:0] next_reference_select_sw, next_reference_select;
  logic [9:0] next_res;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic       next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  sac_pkg::sac_state_type next_state;
  logic [6:0] next_pre_cnt;
  logic [5:0] next_half_cnt;
  logic       next_first_pending, next_single_run, next_auto_run;
  logic [2:0] next_sync_cnt;
  logic [1:0] next_trig_meta, next_trig_sync;
  logic       next_trig_prev, next_sample_hold, next_converter_clk, next_active;

  logic        do_write, do_read, conv_edge, half_edge, finish, trig_level, trig_rise;
  logic        start_write, run_ok;
  logic [6:0]  div_half;
  logic [5:0]  conv_len, sample_at;
  logic [7:0]  byte_high, byte_low, ctrl_a, ctrl_b, insel;

  always_comb begin
    // power-of-two divide
    // Shift in eight bits so the largest ratio does not wrap to zero
    div_half = (divsel == 3'h0) ? 7'h00 : 7'(((8'h01 << divsel) >> 1) - 8'h01);
    half_edge = enable && (pre_cnt >= div_half);
    conv_edge = half_edge && !converter_clk;
    conv_len  = first_pending ? 6'(2 * sac_pkg::FIRST_CYCLES) : 6'(2 * sac_pkg::NORMAL_CYCLES);
    sample_at = first_pending ? 6'(sac_pkg::FIRST_SAMPLE_HALF) :
                auto_run ? 6'(sac_pkg::AUTO_SAMPLE_HALF) : 6'(sac_pkg::NORMAL_SAMPLE_HALF);
    finish    = (state == sac_pkg::SAC_CONV) && half_edge && (half_cnt == conv_len - 6'h01);
    trig_level = (trig_sel == sac_pkg::SRC_FREE) ? done : trig_sync[1];
    trig_rise = trig_level && !trig_prev;
    do_write  = aw_held && w_held && !s_axi_bvalid;
    do_read   = s_axi_arvalid && s_axi_arready;
    start_write = do_write && aw_addr == sac_pkg::ADDR_CTRL_A && w_strb[0] &&
                  w_data[sac_pkg::BIT_START];
    run_ok = enable && !power_gate;
    byte_low  = left ? {res[1:0], 6'h00} : res[7:0];
    byte_high = left ? res[9:2] : {6'h00, res[9:8]};
    ctrl_a = {enable, start, auto_en, done, irq_en, divsel};
    ctrl_b = {5'h00, trig_sel};
    insel  = {reference_select_sw, left, 1'b0, mux_sw};
  end

  // Bus side
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_awready = 1'b0;
    next_wready  = 1'b0;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr <= sac_pkg::ADDR_POWER && aw_addr[1:0] == 2'b00) ?
                     sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
    end
    next_awready = !aw_held && !s_axi_awready && !s_axi_bvalid && !next_aw_held;
    next_wready  = !w_held && !s_axi_wready && !s_axi_bvalid && !next_w_held;
    next_arready = !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid;
    if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) next_arready = 1'b1;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp  = sac_pkg::RESP_OKAY;
      next_arready = 1'b0;
      case (s_axi_araddr)
        sac_pkg::ADDR_CTRL_A:   next_rdata = {24'h000000, ctrl_a};
        sac_pkg::ADDR_CTRL_B:   next_rdata = {24'h000000, ctrl_b};
        sac_pkg::ADDR_INSEL:    next_rdata = {24'h000000, insel};
        sac_pkg::ADDR_RES_LOW:  next_rdata = {24'h000000, byte_low};
        sac_pkg::ADDR_RES_HIGH: next_rdata = {24'h000000, byte_high};
        sac_pkg::ADDR_POWER:    next_rdata = {31'h00000000, power_gate};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = sac_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Register file and sequencer
  always_comb begin
    next_power_gate = power_gate;
    next_enable     = enable;
    next_start      = start;
    next_auto_en    = auto_en;
    next_done       = done;
    next_irq_en     = irq_en;
    next_left       = left;
    next_divsel     = divsel;
    next_trig_sel   = trig_sel;
    next_mux_sw     = mux_sw;
    next_reference_select_sw    = reference_select_sw;
    next_res        = res;
    next_locked     = locked;
    next_state      = state;
    next_half_cnt   = half_cnt;
    next_first_pending = first_pending;
    next_single_run = single_run;
    next_auto_run   = auto_run;
    next_sync_cnt   = sync_cnt;
    next_trig_meta  = {trig_meta[0], trigger_in[trig_sel[2:0] % TRIG_WIDTH]};
    next_trig_sync  = {trig_sync[0], trig_meta[1]};
    next_trig_prev  = trig_level;
    next_sample_hold = 1'b0;
    next_channel_select   = channel_select;
    next_reference_select = reference_select;
    // prescaler held in reset while disabled
    next_pre_cnt       = half_edge ? 7'h00 : pre_cnt + 7'h01;
    next_converter_clk = half_edge ? !converter_clk : converter_clk;
    if (!enable) begin
      next_pre_cnt       = 7'h00;
      next_converter_clk = 1'b0;
    end
    if (do_write) begin
      case (aw_addr)
        sac_pkg::ADDR_CTRL_A: if (w_strb[0]) begin
          next_enable = w_data[sac_pkg::BIT_ENABLE];
          next_auto_en = w_data[sac_pkg::BIT_AUTO];
          next_irq_en = w_data[sac_pkg::BIT_IE];
          next_divsel = w_data[2:0];
          if (w_data[sac_pkg::BIT_DONE]) next_done = 1'b0;
          if (!w_data[sac_pkg::BIT_ENABLE]) next_first_pending = 1'b1;
        end
        sac_pkg::ADDR_CTRL_B: if (w_strb[0]) next_trig_sel = w_data[2:0];
        sac_pkg::ADDR_INSEL: if (w_strb[0]) begin
          next_mux_sw  = w_data[3:0];
          next_left    = w_data[sac_pkg::BIT_LEFT];
          next_reference_select_sw = w_data[7:6];
        end
        sac_pkg::ADDR_POWER: if (w_strb[0]) next_power_gate = w_data[0];
        default: ;
      endcase
    end
    if (do_read && s_axi_araddr == sac_pkg::ADDR_RES_LOW) next_locked = 1'b1;
    if (do_read && s_axi_araddr == sac_pkg::ADDR_RES_HIGH) next_locked = 1'b0;
    // copy only tracks when enabled, outside a conversion or in its last two half cycles
    if (enable && (state != sac_pkg::SAC_CONV ||
                   (half_cnt >= conv_len - 6'h02 && half_cnt < conv_len))) begin
      next_channel_select   = mux_sw;
      next_reference_select = reference_select_sw;
    end
    case (state)
      sac_pkg::SAC_IDLE: begin
        // start write converts in any mode
        if (start_write && run_ok) begin
          next_start = 1'b1;
          next_single_run = !auto_en;
          next_auto_run = 1'b0;
          next_state = sac_pkg::SAC_WAIT;
        end else if (auto_en && run_ok && trig_rise && trig_sel != sac_pkg::SRC_FREE) begin
          next_start = 1'b1;
          next_single_run = 1'b0;
          next_auto_run = 1'b1;
          next_sync_cnt = 3'(sac_pkg::SYNC_CPU_CYCLES);
          next_state = sac_pkg::SAC_WAIT;
        end
      end
      sac_pkg::SAC_WAIT: begin
        if (auto_run) begin
          if (sync_cnt != 3'h0) next_sync_cnt = sync_cnt - 3'h1;
          else begin
            next_pre_cnt = 7'h00;
            next_converter_clk = 1'b1;
            next_half_cnt = 6'h01;
            next_state = sac_pkg::SAC_CONV;
          end
        end else if (conv_edge) begin
          next_half_cnt = 6'h01;
          next_state = sac_pkg::SAC_CONV;
        end
      end
      sac_pkg::SAC_CONV: begin
        next_start = 1'b1;
        if (half_edge) next_half_cnt = half_cnt + 6'h01;
        if (half_edge && half_cnt == sample_at - 6'h01) next_sample_hold = 1'b1;
        if (finish) begin
          next_first_pending = 1'b0;
          // flag set even when result is discarded
          next_done = 1'b1;
          if (!locked) next_res = sample_code;
          next_half_cnt = 6'h00;
          next_trig_prev = 1'b1;
          if (auto_en && trig_sel == sac_pkg::SRC_FREE) begin
            next_half_cnt = 6'h01;
            next_auto_run = 1'b0;
          end else begin
            next_start = 1'b0;
            next_state = sac_pkg::SAC_IDLE;
          end
        end
      end
      default: next_state = sac_pkg::SAC_IDLE;
    endcase
    // first conversion after enabling takes the longer path
    if (!enable) begin
      next_state = sac_pkg::SAC_IDLE;
      next_start = 1'b0;
      next_first_pending = 1'b1;
      next_sample_hold = 1'b0;
    end
    next_active = (next_state != sac_pkg::SAC_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_gate <= 1'b1;
      enable <= 1'b0;
      start <= 1'b0;
      auto_en <= 1'b0;
      done <= 1'b0;
      irq_en <= 1'b0;
      left <= 1'b0;
      divsel <= 3'h0;
      trig_sel <= 3'h0;
      mux_sw <= 4'h0;
      reference_select_sw <= 2'h0;
      res <= 10'h000;
      locked <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      state <= sac_pkg::SAC_IDLE;
      pre_cnt <= 7'h00;
      half_cnt <= 6'h00;
      first_pending <= 1'b1;
      single_run <= 1'b0;
      auto_run <= 1'b0;
      sync_cnt <= 3'h0;
      trig_meta <= 2'h0;
      trig_sync <= 2'h0;
      trig_prev <= 1'b0;
      sample_hold <= 1'b0;
      converter_clk <= 1'b0;
      channel_select <= 4'h0;
      reference_select <= 2'h0;
      converter_active <= 1'b0;
      conversion_done_flag <= 1'b0;
    end else begin
      power_gate <= next_power_gate;
      enable <= next_enable;
      start <= next_start;
      auto_en <= next_auto_en;
      done <= next_done;
      irq_en <= next_irq_en;
      left <= next_left;
      divsel <= next_divsel;
      trig_sel <= next_trig_sel;
      mux_sw <= next_mux_sw;
      reference_select_sw <= next_reference_select_sw;
      res <= next_res;
      locked <= next_locked;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      state <= next_state;
      pre_cnt <= next_pre_cnt;
      half_cnt <= next_half_cnt;
      first_pending <= next_first_pending;
      single_run <= next_single_run;
      auto_run <= next_auto_run;
      sync_cnt <= next_sync_cnt;
      trig_meta <= next_trig_meta;
      trig_sync <= next_trig_sync;
      trig_prev <= next_trig_prev;
      sample_hold <= next_sample_hold;
      converter_clk <= next_converter_clk;
      channel_select <= next_channel_select;
      reference_select <= next_reference_select;
      converter_active <= next_active;
      conversion_done_flag <= next_done;
    end
  end
endmodule : sac_top

// *** tb/sac_top_props.sv ***
// Port-level timing checks for the conversion control block
`timescale 1ns/1ps
module sac_top_props (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       sample_hold,
  input wire logic [3:0] channel_select,
  input wire logic       converter_active,
  input wire logic       conversion_done_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_hold_single: assert property (sample_hold |=> !sample_hold)
    else $error("sample pulse longer than one cycle");
  a_sample_inside: assert property (sample_hold |-> converter_active)
    else $error("sample outside a conversion");
  a_chan_locked: assert property (sample_hold |=> $stable(channel_select))
    else $error("channel moved right after sampling");
  a_min_length: assert property ($rose(converter_active) |-> converter_active [*8])
    else $error("conversion too short");
  a_sample_due: assert property ($rose(converter_active) |-> ##[1:120] sample_hold)
    else $error("no sample after conversion start");
  a_no_early: assert property ($rose(converter_active) |=> !sample_hold)
    else $error("sample at conversion start");
  a_done_cause: assert property ($rose(conversion_done_flag) |->
    $past(converter_active) || $past(converter_active, 2))
    else $error("done flag without a conversion");
  a_done_follows: assert property ($fell(converter_active) |-> ##[0:2] conversion_done_flag)
    else $error("conversion ended without done flag");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : sac_top_props

bind sac_top sac_top_props sac_top_props_i (
  .clk(clk), .resetn(resetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .sample_hold(sample_hold), .channel_select(channel_select),
  .converter_active(converter_active), .conversion_done_flag(conversion_done_flag)
);

// *** tb/sac_partner.sv ***
// Analog core and trigger source stand-in for the conversion control block
`timescale 1ns/1ps
module sac_partner #(
  parameter int TRIG_WIDTH = 8
) (
  input  wire logic                  clk,
  input  wire logic                  sample_hold,
  input  wire logic [3:0]            channel_select,
  input  wire logic [1:0]            reference_select,
  input  wire logic                  fire,
  output logic      [9:0]            sample_code,
  output logic      [TRIG_WIDTH-1:0] trigger_in
);
  // Code encodes the selections seen at the sample point, so a late switch shows up
  always @(posedge clk) begin
    if (sample_hold === 1'b1) begin
      sample_code <= {reference_select, channel_select, 4'h5};
    end
  end
  // Only source one is wired; the rest stay quiet
  assign trigger_in = TRIG_WIDTH'({fire, 1'b0});
endmodule : sac_partner

// *** tb/sac_top_tb.sv ***
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
module sac_top_tb;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        fire = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, reference_select, rd_resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic [7:0]  trigger_in;
  logic [9:0]  sample_code;
  logic [3:0]  channel_select;
  logic        sample_hold, converter_clk, converter_active, conversion_done_flag;
  int          num_errors = 0;
  int          comparisons = 0;
  int          pulses = 0;
  int          act = 0;

  sac_top #(.TRIG_WIDTH(8)) sac_top_i (
    .clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .trigger_in(trigger_in), .sample_code(sample_code), .sample_hold(sample_hold),
    .converter_clk(converter_clk), .channel_select(channel_select),
    .reference_select(reference_select), .converter_active(converter_active),
    .conversion_done_flag(conversion_done_flag));
  sac_partner #(.TRIG_WIDTH(8)) sac_partner_i (
    .clk(clk), .sample_hold(sample_hold), .channel_select(channel_select),
    .reference_select(reference_select), .fire(fire), .sample_code(sample_code),
    .trigger_in(trigger_in));

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (sample_hold === 1'b1) pulses <= pulses + 1;
    if (converter_active === 1'b1) act <= act + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    if (n >= 50) num_errors++;
  endtask : rd

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(sac_pkg::ADDR_CTRL_A);
      n++;
    end while (rd_data[sac_pkg::BIT_START] !== 1'b0 && n < 100);
    if (n >= 100) num_errors++;
  endtask : wait_idle

  // Low byte first, so the pair always comes from one conversion
  task automatic res_check(input logic [7:0] lo, input logic [7:0] hi);
    rd(sac_pkg::ADDR_RES_LOW);
    check(rd_data, {24'h0, lo});
    rd(sac_pkg::ADDR_RES_HIGH);
    check(rd_data, {24'h0, hi});
  endtask : res_check

  task automatic t_reset;
    rd(sac_pkg::ADDR_CTRL_A);
    check(rd_data, 32'h0);
    rd(8'h40);
    check({30'h0, rd_resp}, {30'h0, sac_pkg::RESP_SLVERR});
    wr(sac_pkg::ADDR_INSEL, 32'h5);
    repeat (4) @(posedge clk);
    check({28'h0, channel_select}, 32'h0);
  endtask : t_reset

  // Divide by two keeps every conversion short; expectations use two clocks per cycle
  task automatic t_single;
    wr(sac_pkg::ADDR_POWER, 32'h0);
    wr(sac_pkg::ADDR_CTRL_A, 32'h81);
    repeat (4) @(posedge clk);
    check({28'h0, channel_select}, 32'h5);
    act = 0;
    wr(sac_pkg::ADDR_CTRL_A, 32'hC1);
    rd(sac_pkg::ADDR_CTRL_A);
    check({31'h0, rd_data[6]}, 32'h1);
    wait_idle();
    check({31'h0, act >= 50 && act <= 56}, 32'h1);
    rd(sac_pkg::ADDR_CTRL_A);
    check(rd_data, 32'h91);
    res_check(8'h55, 8'h00);
    wr(sac_pkg::ADDR_CTRL_A, 32'h91);
  endtask : t_single

  task automatic t_left;
    wr(sac_pkg::ADDR_INSEL, 32'h66);
    act = 0;
    wr(sac_pkg::ADDR_CTRL_A, 32'hC1);
    wait_idle();
    check({31'h0, act >= 26 && act <= 32}, 32'h1);
    check({30'h0, reference_select}, 32'h1);
    res_check(8'h40, 8'h59);
    wr(sac_pkg::ADDR_CTRL_A, 32'h91);
  endtask : t_left

  task automatic t_lock;
    // Left aligned so the high byte tells the kept result from the lost one
    wr(sac_pkg::ADDR_INSEL, 32'h27);
    rd(sac_pkg::ADDR_RES_LOW);
    check(rd_data, 32'h40);
    wr(sac_pkg::ADDR_CTRL_A, 32'hC1);
    wait_idle();
    check({31'h0, conversion_done_flag}, 32'h1);
    rd(sac_pkg::ADDR_RES_HIGH);
    check(rd_data, 32'h59);
    wr(sac_pkg::ADDR_CTRL_A, 32'h91);
    wr(sac_pkg::ADDR_CTRL_A, 32'hC1);
    repeat (4) @(posedge clk);
    wr(sac_pkg::ADDR_INSEL, 32'h03);
    wait_idle();
    res_check(8'h75, 8'h00);
    check({28'h0, channel_select}, 32'h3);
    wr(sac_pkg::ADDR_CTRL_A, 32'h91);
  endtask : t_lock

  task automatic t_auto;
    wr(sac_pkg::ADDR_CTRL_B, 32'h1);
    wr(sac_pkg::ADDR_CTRL_A, 32'hA1);
    pulses = 0;
    fire <= 1'b1;
    repeat (10) @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    fire <= 1'b1;
    repeat (150) @(posedge clk);
    check(pulses, 32'h1);
    check({31'h0, conversion_done_flag}, 32'h1);
    check({31'h0, converter_active}, 32'h0);
    fire <= 1'b0;
    wr(sac_pkg::ADDR_CTRL_A, 32'hB1);
    pulses = 0;
    wr(sac_pkg::ADDR_CTRL_A, 32'hE1);
    wait_idle();
    check(pulses, 32'h1);
  endtask : t_auto

  task automatic t_free;
    wr(sac_pkg::ADDR_CTRL_B, 32'h0);
    pulses = 0;
    wr(sac_pkg::ADDR_CTRL_A, 32'hF1);
    repeat (300) @(posedge clk);
    check({31'h0, pulses >= 6}, 32'h1);
    rd(sac_pkg::ADDR_CTRL_A);
    check({31'h0, rd_data[6]}, 32'h1);
    wr(sac_pkg::ADDR_CTRL_A, 32'h81);
    wait_idle();
    wr(sac_pkg::ADDR_CTRL_A, 32'h0);
    repeat (4) @(posedge clk);
    check({30'h0, converter_clk, converter_active}, 32'h0);
  endtask : t_free

  // Divide by eight: 64 clock edges hold exactly eight converter clock rises
  task automatic t_divide;
    int   rises;
    logic prev;
    rises = 0;
    wr(sac_pkg::ADDR_CTRL_A, 32'h83);
    prev = converter_clk;
    repeat (64) begin
      @(posedge clk);
      if (converter_clk === 1'b1 && prev === 1'b0) rises++;
      prev = converter_clk;
    end
    check(rises, 32'h8);
    wr(sac_pkg::ADDR_CTRL_A, 32'h0);
  endtask : t_divide

  task automatic results;
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_single();
    t_left();
    t_lock();
    t_auto();
    t_free();
    t_divide();
    results();
  end

  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule : sac_top_tb
